// file: rtl/pcr_cfg_map.svh
`ifndef PCR_CFG_MAP_SVH
`define PCR_CFG_MAP_SVH
// Register word offsets (byte addresses on the configuration bus).
`define PCR_OFF_CMD_STAT     8'h04
`define PCR_OFF_CLASS        8'h08
`define PCR_OFF_LAT_LINE     8'h0c
`define PCR_OFF_IO_BASE      8'h10
`define PCR_OFF_MEM_BASE     8'h14
`define PCR_OFF_SUBSYS       8'h2c
`define PCR_OFF_ROM_BASE     8'h30
`define PCR_OFF_CAP_PTR      8'h34
`define PCR_OFF_INT_TIMING   8'h3c
`define PCR_OFF_SCRATCH      8'h40
`define PCR_OFF_SIGNATURE    8'h80
`define PCR_OFF_POWER_CAP    8'hc0
// Status and command bit positions.
`define PCR_BIT_PAR_SEEN     31
`define PCR_BIT_SERR_SIG     30
`define PCR_BIT_MABORT       29
`define PCR_BIT_TABORT       28
`define PCR_BIT_DPR          24
`define PCR_BIT_B2B          23
`define PCR_BIT_CAPLIST      20
`define PCR_BIT_SERR_EN      8
`define PCR_BIT_PAR_EN       6
`define PCR_BIT_MASTER_EN    2
`define PCR_BIT_MEM_EN       1
`define PCR_BIT_IO_CTL       0
// Constant field values.
`define PCR_DEVSEL_SPEED     2'h1
`define PCR_BASE_CLASS       8'h02
`define PCR_SUB_CLASS        8'h00
`define PCR_CAP_PTR_VAL      8'hc0
`define PCR_INT_PIN_VAL      8'h01
`define PCR_PME_SUPPORT      5'h1f
`define PCR_AUX_CURRENT      3'h2
`define PCR_PM_LOW_HALF      16'h0201
`endif

// file: rtl/pcr_pkg.sv
package pcr_pkg;
	typedef enum logic [1:0] {
		PCR_LT_IDLE,
		PCR_LT_COUNT,
		PCR_LT_EXPIRED
	} pcr_lt_state_t;
endpackage

// file: rtl/pcr_config_regs.sv
// Function
// R1 - Parity-error-seen bit sets on any detected parity error, regardless of enable.
// R2 - System-error-signalled bit sets whenever the device drove the system error output.
// R3 - Master-abort and target-abort received bits set when own master transaction ends so.
// R4 - Device-select speed field is read-only and always reads 01.
// R5 - Data-parity-reported sets only on PERR involvement, while master, with parity response on.
// R6 - Back-to-back capable bit is read-only and always one.
// R7 - Capability-list bit mirrors controller command register bit 19.
// R8 - With system-error response enabled, address parity error drives the system error output.
// R9 - Parity response off ignores errors; on raises fatal bit 13 of controller status.
// R10 - Command bit 2 gates bus mastering, bit 1 gates memory decode; reset zero.
// R11 - I/O decode control bit: zero enables, one disables; resets to zero.
// R12 - Class code reads base class 02h and subclass 00h, read-only.
// R13 - Low class byte holds read-only revision nibble over step nibble.
// R14 - Latency timer counts clocks from frame start; on expiry stop when grant drops.
// R15 - Cache line size byte is read/write, in doublewords; 8, 16, 32 supported.
// R16 - I/O base stores bits 31..8 writable; bit 0 reads one.
// R17 - Memory base stores bits 31..10 writable; bits 9..0 read zero.
// R18 - Subsystem identity fields are read-only, loaded from serial EEPROM after reset.
// R19 - Boot ROM base bits 31..17 writable, 16..1 zero; all ones reads fffe0001.
// R20 - Boot ROM decodes only when its enable and memory decode enable are both one.
// R21 - Max latency and min grant read-only from EEPROM; interrupt pin reports INTA.
// R22 - Power capability reports PME from all states, D1, D2, aux 010b, no special init.
// R23 - Hardware reset restores defaults; controller software reset leaves registers unchanged.
// R24 - Byte, word and doubleword accesses are all accepted.
// R25 - Driver scratch byte is freely read/write, undefined at power-up, kept on soft reset.
`timescale 1ns/1ps
`include "pcr_cfg_map.svh"

module pcr_config_regs
	import pcr_pkg::*;
#(
	parameter logic [3:0] REVISION_NUM = 4'h1, // Arbitrary revision code.
	parameter logic [3:0] STEP_NUM     = 4'h1, // Arbitrary step code.
	parameter logic [31:0] SIGNATURE   = 32'h5a5a_a5a5 // Arbitrary identity value.
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_rd_i,
	input  wire logic [7:0]  cfg_addr_i,
	input  wire logic [3:0]  cfg_be_i,
	input  wire logic [31:0] cfg_wdata_i,
	output logic      [31:0] cfg_rdata_o,
	input  wire logic        eeprom_load_i,
	input  wire logic [15:0] eeprom_subsys_id_i,
	input  wire logic [15:0] eeprom_subsys_vendor_i,
	input  wire logic [7:0]  eeprom_max_lat_i,
	input  wire logic [7:0]  eeprom_min_gnt_i,
	input  wire logic        cap_list_enable_i,
	input  wire logic        parity_err_i,
	input  wire logic        addr_parity_err_i,
	input  wire logic        perr_involved_i,
	input  wire logic        master_active_i,
	input  wire logic        master_abort_i,
	input  wire logic        target_abort_i,
	input  wire logic        frame_start_i,
	input  wire logic        frame_active_i,
	input  wire logic        gnt_n_i,
	output logic             serr_o,
	output logic             fatal_bus_error_o,
	output logic             master_stop_o,
	output logic             bus_master_enable_o,
	output logic             memory_decode_enable_o,
	output logic             io_decode_enable_o,
	output logic             boot_rom_decode_o,
	output logic      [7:0]  cache_line_words_o,
	output logic      [23:0] io_base_o,
	output logic      [21:0] mem_base_o,
	output logic      [13:0] rom_base_o
);

	// Byte-lane merge shared by the command, I/O base, memory base and boot ROM words.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address match for one decoded offset, on word address bits 7..2.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction

	logic [31:0]   cmd_word;
	logic [15:0]   cmd_r;
	logic          par_seen_r;
	logic          serr_sig_r;
	logic          mabort_r;
	logic          tabort_r;
	logic          dpr_r;
	logic [7:0]    lat_timer_r;
	logic [7:0]    cache_line_r;
	logic [23:0]   io_base_r;
	logic [21:0]   mem_base_r;
	logic [14:0]   rom_base_r;
	logic          rom_en_r;
	logic [7:0]    int_line_r;
	logic [7:0]    scratch_r;
	logic [15:0]   subsys_id_r;
	logic [15:0]   subsys_vendor_r;
	logic [7:0]    max_lat_r;
	logic [7:0]    min_gnt_r;
	logic [7:0]    lt_count_r;
	pcr_lt_state_t lt_state_r;
	logic          serr_now;
	logic [31:0]   wmerge;
	logic [31:0]   status_clr;
	logic [31:0]   cmd_merge;
	logic [31:0]   io_merge;
	logic [31:0]   mem_merge;
	logic [31:0]   rom_merge;

	// The host sees one flat 32-bit word per offset, but only a few of its bits
	// are flip-flops. The command and base address words are therefore rebuilt in full
	// from their stored bits and constant bits, merged lane by lane with the incoming
	// data, and only the implemented slice is kept. This keeps byte, word and
	// doubleword writes behaving the same way for every register.
	//
	// A hazard worth knowing: the constant bits that take part in the merge are
	// thrown away afterwards, so a write can never turn a read-only bit into a
	// stored one. Anything that must read back differently has to be a real
	// flip-flop below, not a constant in the merge.
	assign cmd_word = {16'h0000, cmd_r};
	assign wmerge   = merge_bytes(32'h0000_0000, cfg_wdata_i, cfg_be_i); // R24

	// Merged images of the command, I/O, memory and boot ROM words; the owning process keeps its slice.
	assign cmd_merge = merge_bytes(cmd_word, cfg_wdata_i, cfg_be_i); // R24
	assign io_merge  = merge_bytes({io_base_r, 8'h01}, cfg_wdata_i, cfg_be_i); // R24
	assign mem_merge = merge_bytes({mem_base_r, 10'h000}, cfg_wdata_i, cfg_be_i); // R24
	assign rom_merge = merge_bytes({rom_base_r, 16'h0000, rom_en_r}, cfg_wdata_i,
		cfg_be_i); // R24

	// Status clear mask: only a write to the command and status word clears
	// anything, and only in the lanes that were enabled. Disabled lanes merge as
	// zero, which is why a status flag survives a byte write to the command half.
	assign status_clr = (cfg_wr_i && hit(cfg_addr_i, `PCR_OFF_CMD_STAT)) ? wmerge
		: 32'h0000_0000;

	// Command word: only implemented bits are writable; hardware reset clears all.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_r <= 16'h0000; // R23
		end else if (cfg_wr_i && hit(cfg_addr_i, `PCR_OFF_CMD_STAT)) begin
			cmd_r <= cmd_merge[15:0] & 16'h0147; // R24
		end
	end

	assign bus_master_enable_o    = cmd_r[`PCR_BIT_MASTER_EN]; // R10
	assign memory_decode_enable_o = cmd_r[`PCR_BIT_MEM_EN]; // R10
	assign io_decode_enable_o     = ~cmd_r[`PCR_BIT_IO_CTL]; // R11
	assign boot_rom_decode_o      = rom_en_r & cmd_r[`PCR_BIT_MEM_EN]; // R20

	// System error output; registered so it is a clean level for one cycle.
	assign serr_now = addr_parity_err_i & cmd_r[`PCR_BIT_SERR_EN]; // R8
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			serr_o            <= 1'b0;
			fatal_bus_error_o <= 1'b0;
		end else begin
			serr_o            <= serr_now; // R8
			fatal_bus_error_o <= parity_err_i & cmd_r[`PCR_BIT_PAR_EN]; // R9
		end
	end

	// Sticky status flags: write one clears, and a new event in the same cycle wins.
	// Letting the event win means software can never lose an error that arrives
	// while it is acknowledging an earlier one; at worst it sees the flag again.
	// The flags are set from single-cycle event inputs, so whoever drives those
	// must hold each event for at least one full clock.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			par_seen_r <= 1'b0;
			serr_sig_r <= 1'b0;
			mabort_r   <= 1'b0;
			tabort_r   <= 1'b0;
			dpr_r      <= 1'b0;
		end else begin
			par_seen_r <= parity_err_i | (par_seen_r & ~status_clr[`PCR_BIT_PAR_SEEN]); // R1
			serr_sig_r <= serr_o | (serr_sig_r & ~status_clr[`PCR_BIT_SERR_SIG]); // R2
			mabort_r   <= master_abort_i | (mabort_r & ~status_clr[`PCR_BIT_MABORT]); // R3
			tabort_r   <= target_abort_i | (tabort_r & ~status_clr[`PCR_BIT_TABORT]); // R3
			dpr_r      <= (perr_involved_i & master_active_i & cmd_r[`PCR_BIT_PAR_EN]) // R5
				| (dpr_r & ~status_clr[`PCR_BIT_DPR]);
		end
	end

	// Latency timer and cache line size bytes.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lat_timer_r  <= 8'h00;
			cache_line_r <= 8'h00;
		end else if (cfg_wr_i && hit(cfg_addr_i, `PCR_OFF_LAT_LINE)) begin
			if (cfg_be_i[1]) begin
				lat_timer_r <= cfg_wdata_i[15:8]; // R14
			end
			if (cfg_be_i[0]) begin
				cache_line_r <= cfg_wdata_i[7:0]; // R15
			end
		end
	end
	assign cache_line_words_o = cache_line_r; // R15

	// Latency timer: counts from frame start, then asks the master to stop once
	// grant is withdrawn while the frame is still held.
	// The count is reloaded at every frame start, so a timer value written in the
	// middle of a transaction only takes effect on the next one. A programmed
	// value of zero expires at once, which makes the master give up the bus as
	// soon as grant drops; that is the cheapest setting for other masters.
	// The stop request itself is combinational so it follows grant without lag.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lt_state_r <= PCR_LT_IDLE;
			lt_count_r <= 8'h00;
		end else begin
			case (lt_state_r)
				PCR_LT_IDLE: begin
					if (frame_start_i) begin
						lt_count_r <= lat_timer_r; // R14
						lt_state_r <= (lat_timer_r == 8'h00) ? PCR_LT_EXPIRED : PCR_LT_COUNT;
					end
				end
				PCR_LT_COUNT: begin
					if (!frame_active_i) begin
						lt_state_r <= PCR_LT_IDLE;
					end else if (lt_count_r <= 8'h01) begin
						lt_count_r <= 8'h00;
						lt_state_r <= PCR_LT_EXPIRED; // R14
					end else begin
						lt_count_r <= lt_count_r - 8'h01;
					end
				end
				PCR_LT_EXPIRED: begin
					if (!frame_active_i) begin
						lt_state_r <= PCR_LT_IDLE;
					end
				end
				default: begin
					lt_state_r <= PCR_LT_IDLE;
				end
			endcase
		end
	end
	assign master_stop_o = (lt_state_r == PCR_LT_EXPIRED) & frame_active_i & gnt_n_i; // R14

	// Base address registers; unimplemented low bits never store anything.
	// Software sizes each window by writing all ones and reading back: the bits
	// that stay zero tell it how large the window is. The I/O window therefore
	// claims 256 bytes, the memory window 1 KB. The boot ROM window keeps bit 17
	// as a stored bit so that the all-ones probe reads back the expected pattern;
	// decoders downstream only use bits 31..18 of it.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_base_r  <= 24'h000000;
			mem_base_r <= 22'h000000;
			rom_base_r <= 15'h0000;
			rom_en_r   <= 1'b0;
		end else if (cfg_wr_i) begin
			if (hit(cfg_addr_i, `PCR_OFF_IO_BASE)) begin
				io_base_r <= io_merge[31:8]; // R16
			end
			if (hit(cfg_addr_i, `PCR_OFF_MEM_BASE)) begin
				mem_base_r <= mem_merge[31:10]; // R17
			end
			if (hit(cfg_addr_i, `PCR_OFF_ROM_BASE)) begin
				rom_base_r <= rom_merge[31:17]; // R19
				if (cfg_be_i[0]) begin
					rom_en_r <= cfg_wdata_i[0]; // R20
				end
			end
		end
	end
	assign io_base_o  = io_base_r;
	assign mem_base_o = mem_base_r;
	assign rom_base_o = rom_base_r[14:1];

	// Interrupt line and driver scratch; the scratch byte has no reset so a
	// controller soft reset or hardware reset never disturbs what a driver left.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			int_line_r <= 8'h00;
		end else if (cfg_wr_i && hit(cfg_addr_i, `PCR_OFF_INT_TIMING) && cfg_be_i[0]) begin
			int_line_r <= cfg_wdata_i[7:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (cfg_wr_i && hit(cfg_addr_i, `PCR_OFF_SCRATCH) && cfg_be_i[1]) begin
			scratch_r <= cfg_wdata_i[15:8]; // R25
		end
	end

	// Values recalled from the serial EEPROM; the loader pulses after reset.
	// Until that pulse arrives these fields read zero, so software that probes
	// the identity too early sees an empty subsystem rather than stale values.
	// Host writes never reach them: they are read-only from the bus side.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			subsys_id_r     <= 16'h0000;
			subsys_vendor_r <= 16'h0000;
			max_lat_r       <= 8'h00;
			min_gnt_r       <= 8'h00;
		end else if (eeprom_load_i) begin
			subsys_id_r     <= eeprom_subsys_id_i; // R18
			subsys_vendor_r <= eeprom_subsys_vendor_i; // R18
			max_lat_r       <= eeprom_max_lat_i; // R21
			min_gnt_r       <= eeprom_min_gnt_i; // R21
		end
	end

	// Read data is registered; unmapped offsets read zero.
	// Registering costs one cycle of read latency but keeps the wide read mux
	// off the host's timing path. The data stands until the next read, so the
	// host may take it at any edge after the strobe. Byte enables are ignored
	// on reads: the full word is always returned and the host picks its lanes.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_rdata_o <= 32'h0000_0000;
		end else if (cfg_rd_i) begin
			case ({2'b00, cfg_addr_i[7:2]})
				`PCR_OFF_CMD_STAT >> 2: cfg_rdata_o <= {par_seen_r, serr_sig_r, mabort_r, // R1
					tabort_r, 1'b0, `PCR_DEVSEL_SPEED, dpr_r, 1'b1, // R4 R6
					2'b00, cap_list_enable_i, 4'h0, cmd_word[15:0]}; // R7
				`PCR_OFF_CLASS >> 2: cfg_rdata_o <= {`PCR_BASE_CLASS, `PCR_SUB_CLASS, // R12
					8'h00, REVISION_NUM, STEP_NUM}; // R13
				`PCR_OFF_LAT_LINE >> 2: cfg_rdata_o <= {16'h0000, lat_timer_r, cache_line_r};
				`PCR_OFF_IO_BASE >> 2: cfg_rdata_o <= {io_base_r, 8'h01}; // R16
				`PCR_OFF_MEM_BASE >> 2: cfg_rdata_o <= {mem_base_r, 10'h000}; // R17
				`PCR_OFF_SUBSYS >> 2: cfg_rdata_o <= {subsys_id_r, subsys_vendor_r}; // R18
				`PCR_OFF_ROM_BASE >> 2: cfg_rdata_o <= {rom_base_r, 16'h0000, rom_en_r}; // R19
				`PCR_OFF_CAP_PTR >> 2: cfg_rdata_o <= {24'h000000, `PCR_CAP_PTR_VAL};
				`PCR_OFF_INT_TIMING >> 2: cfg_rdata_o <= {max_lat_r, min_gnt_r, // R21
					`PCR_INT_PIN_VAL, int_line_r};
				`PCR_OFF_SCRATCH >> 2: cfg_rdata_o <= {16'h0000, scratch_r, 8'h00}; // R25
				`PCR_OFF_SIGNATURE >> 2: cfg_rdata_o <= SIGNATURE;
				`PCR_OFF_POWER_CAP >> 2: cfg_rdata_o <= {`PCR_PME_SUPPORT, 1'b1, 1'b1, // R22
					`PCR_AUX_CURRENT, 1'b0, 5'h00, `PCR_PM_LOW_HALF};
				default: cfg_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // pcr_config_regs

// file: test/pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model (
	input  wire logic        clk_i,
	output logic             cfg_wr_o,
	output logic             cfg_rd_o,
	output logic      [7:0]  cfg_addr_o,
	output logic      [3:0]  cfg_be_o,
	output logic      [31:0] cfg_wdata_o,
	input  wire logic [31:0] cfg_rdata_i
);
	// Bus starts quiet so no access is seen during reset.
	initial begin
		{cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
	end
	// One strobe cycle per write; idle address and data lines are inverted so stale data never looks valid.
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge clk_i);
		{cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {1'b1, a, be, d};
		@(negedge clk_i);
		cfg_wr_o = 1'b0;
		{cfg_addr_o, cfg_wdata_o} = ~{a, d};
	endtask
	// Read data is registered, so it is taken one cycle after the strobe edge.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk_i);
		{cfg_rd_o, cfg_addr_o, cfg_be_o} = {1'b1, a, 4'hf};
		@(negedge clk_i);
		d = cfg_rdata_i;
		cfg_rd_o = 1'b0;
		cfg_addr_o = ~a;
	endtask
endmodule // pcr_host_model

// file: test/pcr_config_regs_asserts.sv
`timescale 1ns/1ps
module pcr_config_regs_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cfg_wr_i,
	input wire logic        cfg_rd_i,
	input wire logic [7:0]  cfg_addr_i,
	input wire logic [3:0]  cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic        cap_list_enable_i,
	input wire logic        frame_active_i,
	input wire logic        gnt_n_i,
	input wire logic        master_stop_o,
	input wire logic        bus_master_enable_o,
	input wire logic        memory_decode_enable_o,
	input wire logic        io_decode_enable_o,
	input wire logic        boot_rom_decode_o,
	input wire logic [7:0]  cache_line_words_o
);
	// Decoded strobes keep the properties short.
	logic cmd_wr, cls_wr, rd04, rd08, rd30;
	assign cmd_wr = cfg_wr_i && cfg_addr_i == 8'h04 && cfg_be_i[0];
	assign cls_wr = cfg_wr_i && cfg_addr_i == 8'h0c && cfg_be_i[0];
	assign rd04 = cfg_rd_i && cfg_addr_i == 8'h04;
	assign rd08 = cfg_rd_i && cfg_addr_i == 8'h08;
	assign rd30 = cfg_rd_i && cfg_addr_i == 8'h30;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_io_polarity: assert property (cmd_wr |=> io_decode_enable_o == !$past(cfg_wdata_i[0]))
		else $error("io decode polarity wrong");
	a_master_gate: assert property (cmd_wr |=> bus_master_enable_o == $past(cfg_wdata_i[2]))
		else $error("bus master enable wrong");
	a_mem_gate: assert property (cmd_wr |=> memory_decode_enable_o == $past(cfg_wdata_i[1]))
		else $error("memory decode enable wrong");
	a_rom_needs_mem: assert property (boot_rom_decode_o |-> memory_decode_enable_o)
		else $error("boot rom decodes without memory enable");
	a_stop_on_gnt: assert property (master_stop_o |-> frame_active_i && gnt_n_i)
		else $error("master stop without frame and released grant");
	a_class_code: assert property (rd08 |=> cfg_rdata_o[31:16] == 16'h0200)
		else $error("class code wrong");
	a_status_const: assert property (rd04 |=> cfg_rdata_o[26:25] == 2'b01 && cfg_rdata_o[23])
		else $error("devsel or back to back bits wrong");
	a_cap_mirror: assert property (rd04 |=> cfg_rdata_o[20] == $past(cap_list_enable_i))
		else $error("capability bit not mirrored");
	a_rom_low_zero: assert property (rd30 |=> cfg_rdata_o[16:1] == 16'h0)
		else $error("boot rom low bits not zero");
	a_line_size: assert property (cls_wr |=> cache_line_words_o == $past(cfg_wdata_i[7:0]))
		else $error("cache line size not stored");
	c_cmd_wr: cover property (cmd_wr);
	c_rom_dec: cover property (boot_rom_decode_o);
	c_stop: cover property (master_stop_o);
endmodule // pcr_config_regs_chk
bind pcr_config_regs pcr_config_regs_chk pcr_config_regs_chk_inst (
	.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
	.cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
	.cfg_rdata_o(cfg_rdata_o), .cap_list_enable_i(cap_list_enable_i),
	.frame_active_i(frame_active_i), .gnt_n_i(gnt_n_i), .master_stop_o(master_stop_o),
	.bus_master_enable_o(bus_master_enable_o), .memory_decode_enable_o(memory_decode_enable_o),
	.io_decode_enable_o(io_decode_enable_o), .boot_rom_decode_o(boot_rom_decode_o),
	.cache_line_words_o(cache_line_words_o));

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_i, rst_i, wr, rd, ld, cap, par, apar, perr, mact, mab, tab, fst, fact, gnt_n;
	logic [7:0]  addr, cache_line_words;
	logic [3:0]  be;
	logic [31:0] wd, rdat;
	logic        serr, fatal, stop, bm, me, ioe, romd;
	logic [23:0] iob;
	logic [21:0] mb;
	logic [13:0] rb;
	logic [1:0]  sv;
	int          err_count, n_compared;
	localparam logic [7:0]  RA [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30, 8'h34, 8'h80};
	localparam logic [31:0] RE [8] = '{32'h02900000, 32'h02000011, 32'h0, 32'h1, 32'h0, 32'h0,
		32'hc0, 32'h5a5aa5a5};
	pcr_host_model pcr_host_model_inst (.clk_i(clk_i), .cfg_wr_o(wr), .cfg_rd_o(rd),
		.cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wd), .cfg_rdata_i(rdat));
	pcr_config_regs pcr_config_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(wr),
		.cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
		.eeprom_load_i(ld), .eeprom_subsys_id_i(16'hbeef), .eeprom_subsys_vendor_i(16'h3c4d),
		.eeprom_max_lat_i(8'h12), .eeprom_min_gnt_i(8'h34), .cap_list_enable_i(cap),
		.parity_err_i(par), .addr_parity_err_i(apar), .perr_involved_i(perr),
		.master_active_i(mact), .master_abort_i(mab), .target_abort_i(tab),
		.frame_start_i(fst), .frame_active_i(fact), .gnt_n_i(gnt_n), .serr_o(serr),
		.fatal_bus_error_o(fatal), .master_stop_o(stop), .bus_master_enable_o(bm),
		.memory_decode_enable_o(me), .io_decode_enable_o(ioe), .boot_rom_decode_o(romd),
		.cache_line_words_o(cache_line_words), .io_base_o(iob), .mem_base_o(mb), .rom_base_o(rb));
	// Free-running clock at 40 MHz.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		pcr_host_model_inst.wr(a, b, d);
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		pcr_host_model_inst.rd(a, d);
		chk($sformatf("reg %h", a), e, d & m);
	endtask
	// Event inputs {par, apar, perr, mact, mab, tab, fst} held for one cycle.
	task automatic pulse(input logic [6:0] v);
		@(negedge clk_i);
		{par, apar, perr, mact, mab, tab, fst} = v;
		@(negedge clk_i);
		sv = {serr, fatal};
		{par, apar, perr, mact, mab, tab, fst} = '0;
	endtask
	task automatic give_verdict;
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// A hang costs far more than the roughly 120 cycles the sequence needs.
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
	// Main sequence; every input is driven from time zero.
	initial begin
		{ld, par, apar, perr, mact, mab, tab, fst, fact} = '0;
		{rst_i, cap, gnt_n, err_count, n_compared} = {3'b111, 64'd0};
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		for (int i = 0; i < 8; i++) r(RA[i], '1, RE[i]);
		r(8'hc0, 32'hffe00000, 32'hfe800000);
		chk("io_en", 1, ioe);
		@(negedge clk_i) ld = 1'b1;
		@(negedge clk_i) ld = 1'b0;
		w(8'h2c, 4'hf, '1);
		r(8'h2c, '1, 32'hbeef3c4d);
		w(8'h3c, 4'hf, '1);
		r(8'h3c, '1, 32'h123401ff);
		w(8'h30, 4'hf, '1);
		r(8'h30, '1, 32'hfffe0001);
		chk("rom_base", 14'h3fff, rb);
		chk("rom_dec", 0, romd);
		w(8'h04, 4'h1, 32'h2);
		chk("rom_dec", 1, romd);
		w(8'h04, 4'h3, 32'h147);
		r(8'h04, 32'hffff, 32'h147);
		chk("en", 3'b110, {bm, me, ioe});
		w(8'h04, 4'h1, 32'h0);
		r(8'h04, 32'hffff, 32'h100);
		w(8'h10, 4'h2, 32'h0000ab00);
		r(8'h10, '1, 32'h0000ab01);
		chk("io_base", 24'hab, iob);
		w(8'h14, 4'hf, '1);
		r(8'h14, '1, 32'hfffffc00);
		chk("mem_base", 22'h3fffff, mb);
		foreach (RE[i]) if (i < 3) begin
			w(8'h0c, 4'h1, 32'h8 << i);
			r(8'h0c, '1, 32'h8 << i);
		end
		w(8'h0c, 4'h2, 32'h300);
		w(8'h08, 4'hf, '1);
		r(8'h08, '1, 32'h02000011);
		w(8'h40, 4'hf, '1);
		r(8'h40, 32'hffff, 32'hff00);
		w(8'h50, 4'hf, '1);
		r(8'h50, '1, 32'h0);
		pulse(7'h40);
		chk("fatal_off", 0, sv[0]);
		pulse(7'h20);
		chk("serr", 1, sv[1]);
		pulse(7'h06);
		pulse(7'h18);
		r(8'h04, 32'hf1000000, 32'hf0000000);
		w(8'h04, 4'h8, 32'hf1000000);
		r(8'h04, 32'hf1000000, 32'h0);
		w(8'h04, 4'h1, 32'h44);
		pulse(7'h40);
		chk("fatal_on", 1, sv[0]);
		pulse(7'h18);
		r(8'h04, 32'hf1000000, 32'h81000000);
		{fact, gnt_n} = 2'b10;
		pulse(7'h01);
		repeat (6) @(negedge clk_i);
		chk("stop_gnt", 0, stop);
		gnt_n = 1'b1;
		#1 chk("stop", 1, stop);
		@(negedge clk_i) {fact, rst_i} = 2'b01;
		@(negedge clk_i) rst_i = 1'b0;
		r(8'h30, '1, 32'h0);
		r(8'h04, 32'hffff, 32'h0);
		give_verdict();
	end
endmodule // tb
